// ---- inc/timer16_map.svh ----
// Register map, field positions and fixed values of the timer16 core
// Functional notes
// RULE1 - Latch survives low-byte writes for reuse
// RULE2 - Clock select zero stops the counter
// RULE3 - Low read fills latch; low write loads
// RULE4 - Counter upper byte access hits latch
// RULE5 - Tick clears, increments or decrements counter
// RULE6 - Counter accessible with tick stopped
// RULE7 - Processor write beats counting that cycle
// RULE8 - Waveform mode field sets count sequence
// RULE9 - Overflow flag set per mode, requests interrupt
// RULE10 - Selected source edge copies counter to capture
// RULE11 - Capture flag set in copy cycle
// RULE12 - Capture flag interrupts; ack or one clears
// RULE13 - Capture low read fills latch first
// RULE14 - Capture writable only in capture-top modes
// RULE15 - Comparator select switches capture source
// RULE16 - Sources synchronised; filter adds four cycles
// RULE17 - Filter and edge off in capture-top modes
// RULE18 - Filter changes after four equal samples
// RULE19 - Filter enable bit, runs on system clock
// RULE20 - New capture overwrites unread value
// RULE21 - Capture pin sensed even when driven
// RULE22 - Software toggles edge, clears flag after
// RULE23 - One latch shared by all wide registers
// RULE24 - Bottom at 0x0000, maximum at 0xffff
// RULE25 - Edge select picks rising or falling
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH
`define A_CTRLA 4'h0
`define A_CTRLB 4'h1
`define A_CNTL 4'h2
`define A_CNTH 4'h3
`define A_CAPL 4'h4
`define A_CAPH 4'h5
`define A_FLAGS 4'h6
`define A_IMSK 4'h7
`define A_COMPARATOR_CTRL_STATUS 4'h8
`define A_CMPAL 4'h9
`define A_CMPAH 4'ha
`define A_CMPBL 4'hb
`define A_CMPBH 4'hc
`define FL_OVF 0
`define FL_CAP 5
`define AC_SEL 2
`define LO_B 7:0
`define HI_B 15:8
`define R1 1'b0
`define R8 8'h00
`define R16 16'h0000
`define STEP 16'h0001
`define BOTTOM 16'h0000
`define MAXV 16'hffff
`define TOP8 16'h00ff
`define TOP9 16'h01ff
`define TOP10 16'h03ff
`define NF_LEN 4
`define PT_8 0
`define PT_64 1
`define PT_256 2
`define PT_1024 3
`define SY_EXT 0
`define SY_PIN 1
`define SY_CMP 2
`define SY_N 3
`endif

// ---- inc/timer16_pkg.sv ----
// Types shared by the timer16 core
package timer16_pkg;
   typedef enum logic [2:0] {
      CS_STOP = 3'h0, CS_CLK = 3'h1, CS_P8 = 3'h2, CS_P64 = 3'h3,
      CS_P256 = 3'h4, CS_P1024 = 3'h5, CS_EXT_FALL = 3'h6, CS_EXT_RISE = 3'h7
   } clk_sel_e;
   typedef enum logic [3:0] {
      W_NORM = 4'h0, W_PC8 = 4'h1, W_PC9 = 4'h2, W_PC10 = 4'h3,
      W_CTC_A = 4'h4, W_FP8 = 4'h5, W_FP9 = 4'h6, W_FP10 = 4'h7,
      W_PFC_C = 4'h8, W_PFC_A = 4'h9, W_PC_C = 4'ha, W_PC_A = 4'hb,
      W_CTC_C = 4'hc, W_RSV = 4'hd, W_FP_C = 4'he, W_FP_A = 4'hf
   } wgm_e;
   typedef enum logic [1:0] {
      K_NORM = 2'h0, K_CTC = 2'h1, K_FAST = 2'h2, K_DUAL = 2'h3
   } kind_e;
   typedef struct packed {
      logic [5:0] out_mode;
      logic [1:0] wgm_lo;
   } ctrl_a_s;
   typedef struct packed {
      logic nf_en;
      logic edge_rise;
      logic rsvd;
      logic [1:0] wgm_hi;
      clk_sel_e cs;
   } ctrl_b_s;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } bus_req_s;
endpackage

// ---- src/timer16_core.sv ----
// 16-bit timer/counter core with input capture unit
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "timer16_map.svh"

module timer16_core (
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic [3:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   input wire logic [3:0] PRESCALE_TICK_I,
   input wire logic EXT_COUNT_PIN_I,
   input wire logic CAPTURE_PIN_I,
   input wire logic COMPARATOR_OUTPUT_I,
   input wire logic OVF_IRQ_ACK_I,
   input wire logic CAP_IRQ_ACK_I,
   output logic OVF_IRQ_O,
   output logic CAP_IRQ_O,
   output logic BOTTOM_O,
   output logic MAX_O
);

   // ************************************
   // Declarations
   // ************************************
   timer16_pkg::bus_req_s req;
   timer16_pkg::ctrl_a_s ctrl_a_q, ctrl_a_d;
   timer16_pkg::ctrl_b_s ctrl_b_q, ctrl_b_d;
   timer16_pkg::wgm_e mode;
   timer16_pkg::kind_e kind;
   logic [`SY_N-1:0] s1_q, s1_d, s2_q, s2_d;
   logic ext_q, ext_d, tick;
   logic [15:0] cnt_q, cnt_d, cap_q, cap_d;
   logic [15:0] cmpa_q, cmpa_d, cmpb_q, cmpb_d, top_val;
   logic [7:0] latch_q, latch_d, rdata_q, rdata_d;
   logic dir_q, dir_d, ovf_q, ovf_d, capf_q, capf_d;
   logic ovf_ie_q, ovf_ie_d, cap_ie_q, cap_ie_d;
   logic acsel_q, acsel_d, ovf_set, ovf_clr, cap_clr;
   logic cnt_wr, cap_wr, cap_top, src, level, all_eq;
   logic [`NF_LEN-1:0] nf_q, nf_d;
   logic filt, filt_q, filt_d, prev_q, prev_d, cap_evt;

   // Pack the bus signals
   assign req = '{wr: WR_I, rd: RD_I, addr: ADDR_I, wdata: WDATA_I};

   // ************************************
   // Input synchronisers
   // ************************************
   // Two stages per pin; pin read regardless of port drive
   always_comb begin
      s1_d = {COMPARATOR_OUTPUT_I, CAPTURE_PIN_I, EXT_COUNT_PIN_I}; // [RULE21]
      s2_d = s1_q; // [RULE16]
      ext_d = s2_q[`SY_EXT];
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         s1_q <= '0;
         s2_q <= '0;
         ext_q <= `R1;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         ext_q <= ext_d;
      end
   end

   // ************************************
   // Mode decode and tick select
   // ************************************
   // Wide mode field split over both control registers
   assign mode = timer16_pkg::wgm_e'({ctrl_b_q.wgm_hi, ctrl_a_q.wgm_lo}); // [RULE8]

   // Top value, sequence kind, capture-top flag
   always_comb begin
      top_val = `MAXV;
      kind = timer16_pkg::K_NORM;
      cap_top = 1'b0;
      unique case (mode)
         timer16_pkg::W_NORM, timer16_pkg::W_RSV: begin
            top_val = `MAXV;
         end
         timer16_pkg::W_PC8: begin
            top_val = `TOP8;
            kind = timer16_pkg::K_DUAL;
         end
         timer16_pkg::W_PC9: begin
            top_val = `TOP9;
            kind = timer16_pkg::K_DUAL;
         end
         timer16_pkg::W_PC10: begin
            top_val = `TOP10;
            kind = timer16_pkg::K_DUAL;
         end
         timer16_pkg::W_FP8: begin
            top_val = `TOP8;
            kind = timer16_pkg::K_FAST;
         end
         timer16_pkg::W_FP9: begin
            top_val = `TOP9;
            kind = timer16_pkg::K_FAST;
         end
         timer16_pkg::W_FP10: begin
            top_val = `TOP10;
            kind = timer16_pkg::K_FAST;
         end
         timer16_pkg::W_CTC_A: begin
            top_val = cmpa_q;
            kind = timer16_pkg::K_CTC;
         end
         timer16_pkg::W_PFC_A, timer16_pkg::W_PC_A: begin
            top_val = cmpa_q;
            kind = timer16_pkg::K_DUAL;
         end
         timer16_pkg::W_FP_A: begin
            top_val = cmpa_q;
            kind = timer16_pkg::K_FAST;
         end
         timer16_pkg::W_CTC_C: begin
            top_val = cap_q;
            kind = timer16_pkg::K_CTC;
            cap_top = 1'b1;
         end
         timer16_pkg::W_PFC_C, timer16_pkg::W_PC_C: begin
            top_val = cap_q;
            kind = timer16_pkg::K_DUAL;
            cap_top = 1'b1;
         end
         timer16_pkg::W_FP_C: begin
            top_val = cap_q;
            kind = timer16_pkg::K_FAST;
            cap_top = 1'b1;
         end
      endcase
   end

   // Timer tick from the selected source
   always_comb begin
      unique case (ctrl_b_q.cs)
         timer16_pkg::CS_STOP: tick = 1'b0; // [RULE2]
         timer16_pkg::CS_CLK: tick = 1'b1;
         timer16_pkg::CS_P8: tick = PRESCALE_TICK_I[`PT_8];
         timer16_pkg::CS_P64: tick = PRESCALE_TICK_I[`PT_64];
         timer16_pkg::CS_P256: tick = PRESCALE_TICK_I[`PT_256];
         timer16_pkg::CS_P1024: tick = PRESCALE_TICK_I[`PT_1024];
         timer16_pkg::CS_EXT_FALL: tick = ext_q & ~s2_q[`SY_EXT];
         timer16_pkg::CS_EXT_RISE: tick = ~ext_q & s2_q[`SY_EXT];
      endcase
   end

   // ************************************
   // Counter unit
   // ************************************
   assign cnt_wr = req.wr && (req.addr == `A_CNTL);

   // Next count, direction and overflow event
   always_comb begin
      cnt_d = cnt_q;
      dir_d = dir_q;
      ovf_set = 1'b0;
      if (tick) begin
         unique case (kind)
            timer16_pkg::K_NORM: begin
               cnt_d = cnt_q + `STEP; // [RULE5]
               ovf_set = (cnt_q == `MAXV); // [RULE9]
               dir_d = 1'b0;
            end
            timer16_pkg::K_CTC: begin
               cnt_d = (cnt_q == top_val) ? `BOTTOM : cnt_q + `STEP; // [RULE5]
               ovf_set = (cnt_q == `MAXV); // [RULE9]
               dir_d = 1'b0;
            end
            timer16_pkg::K_FAST: begin
               cnt_d = (cnt_q == top_val) ? `BOTTOM : cnt_q + `STEP;
               ovf_set = (cnt_q == top_val); // [RULE9]
               dir_d = 1'b0;
            end
            timer16_pkg::K_DUAL: begin
               if (!dir_q) begin
                  if (cnt_q >= top_val) begin
                     dir_d = 1'b1;
                     cnt_d = cnt_q - `STEP; // [RULE5]
                  end else begin
                     cnt_d = cnt_q + `STEP;
                  end
               end else if (cnt_q == `BOTTOM) begin
                  dir_d = 1'b0;
                  cnt_d = cnt_q + `STEP;
                  ovf_set = 1'b1; // [RULE9]
               end else begin
                  cnt_d = cnt_q - `STEP;
               end
            end
         endcase
      end
      // Processor write wins, tick or not
      if (cnt_wr) begin
         cnt_d = {latch_q, req.wdata}; // [RULE3] [RULE6] [RULE7]
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         cnt_q <= `R16;
         dir_q <= `R1;
      end else begin
         cnt_q <= cnt_d;
         dir_q <= dir_d;
      end
   end

   // Bottom and maximum indications
   assign BOTTOM_O = (cnt_q == `BOTTOM); // [RULE24]
   assign MAX_O = (cnt_q == `MAXV); // [RULE24]

   // ************************************
   // Input capture path
   // ************************************
   // Source mux, four-sample filter, edge detector
   always_comb begin
      src = acsel_q ? s2_q[`SY_CMP] : s2_q[`SY_PIN]; // [RULE15] [RULE16]
      all_eq = (&nf_q) | ~(|nf_q); // [RULE18]
      filt = all_eq ? nf_q[0] : filt_q;
      level = ctrl_b_q.nf_en ? filt : src; // [RULE19]
      nf_d = cap_top ? nf_q : {nf_q[`NF_LEN-2:0], src}; // [RULE17]
      filt_d = cap_top ? filt_q : filt;
      prev_d = cap_top ? prev_q : level;
      cap_evt = !cap_top && (level != prev_q) && (level == ctrl_b_q.edge_rise); // [RULE25]
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         nf_q <= '0;
         filt_q <= `R1;
         prev_q <= `R1;
      end else begin
         nf_q <= nf_d;
         filt_q <= filt_d;
         prev_q <= prev_d;
      end
   end

   // ************************************
   // Register file and shared latch
   // ************************************
   assign cap_wr = req.wr && (req.addr == `A_CAPL) && cap_top;

   // Writes, reads and flag updates
   always_comb begin
      ctrl_a_d = ctrl_a_q;
      ctrl_b_d = ctrl_b_q;
      cmpa_d = cmpa_q;
      cmpb_d = cmpb_q;
      latch_d = latch_q;
      acsel_d = acsel_q;
      ovf_ie_d = ovf_ie_q;
      cap_ie_d = cap_ie_q;
      rdata_d = `R8;
      ovf_clr = OVF_IRQ_ACK_I;
      cap_clr = CAP_IRQ_ACK_I;
      cap_d = cap_q;
      if (req.wr) begin
         unique case (req.addr)
            `A_CTRLA: ctrl_a_d = timer16_pkg::ctrl_a_s'(req.wdata);
            `A_CTRLB: begin
               ctrl_b_d = timer16_pkg::ctrl_b_s'(req.wdata);
               ctrl_b_d.rsvd = 1'b0;
            end
            `A_CNTH, `A_CAPH, `A_CMPAH, `A_CMPBH: latch_d = req.wdata; // [RULE4] [RULE23]
            `A_CAPL: begin
               if (cap_top) begin
                  cap_d = {latch_q, req.wdata}; // [RULE14]
               end
            end
            `A_CMPAL: cmpa_d = {latch_q, req.wdata}; // [RULE23]
            `A_CMPBL: cmpb_d = {latch_q, req.wdata};
            `A_FLAGS: begin
               ovf_clr = OVF_IRQ_ACK_I | req.wdata[`FL_OVF];
               cap_clr = CAP_IRQ_ACK_I | req.wdata[`FL_CAP]; // [RULE12]
            end
            `A_IMSK: begin
               ovf_ie_d = req.wdata[`FL_OVF];
               cap_ie_d = req.wdata[`FL_CAP];
            end
            `A_COMPARATOR_CTRL_STATUS: acsel_d = req.wdata[`AC_SEL]; // [RULE15]
            default: ;
         endcase
      end
      if (req.rd) begin
         unique case (req.addr)
            `A_CTRLA: rdata_d = ctrl_a_q;
            `A_CTRLB: rdata_d = ctrl_b_q;
            `A_CNTL: begin
               rdata_d = cnt_q[`LO_B];
               latch_d = cnt_q[`HI_B]; // [RULE3]
            end
            `A_CNTH, `A_CAPH: rdata_d = latch_q; // [RULE4] [RULE13]
            `A_CAPL: begin
               rdata_d = cap_q[`LO_B];
               latch_d = cap_q[`HI_B]; // [RULE13]
            end
            `A_CMPAL: rdata_d = cmpa_q[`LO_B];
            `A_CMPAH: rdata_d = cmpa_q[`HI_B];
            `A_CMPBL: rdata_d = cmpb_q[`LO_B];
            `A_CMPBH: rdata_d = cmpb_q[`HI_B];
            `A_FLAGS: begin
               rdata_d[`FL_OVF] = ovf_q;
               rdata_d[`FL_CAP] = capf_q;
            end
            `A_IMSK: begin
               rdata_d[`FL_OVF] = ovf_ie_q;
               rdata_d[`FL_CAP] = cap_ie_q;
            end
            `A_COMPARATOR_CTRL_STATUS: rdata_d[`AC_SEL] = acsel_q;
            default: ;
         endcase
      end
      // Capture overwrites any unread value
      if (cap_evt) begin
         cap_d = cnt_q; // [RULE10] [RULE20]
      end
      // Hardware set beats any clear
      ovf_d = ovf_set | (ovf_q & ~ovf_clr); // [RULE9]
      capf_d = cap_evt | (capf_q & ~cap_clr); // [RULE11] [RULE12]
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         ctrl_a_q <= timer16_pkg::ctrl_a_s'(`R8);
         ctrl_b_q <= timer16_pkg::ctrl_b_s'(`R8);
         cap_q <= `R16;
         cmpa_q <= `R16;
         cmpb_q <= `R16;
         latch_q <= `R8;
         rdata_q <= `R8;
         acsel_q <= `R1;
         ovf_q <= `R1;
         capf_q <= `R1;
         ovf_ie_q <= `R1;
         cap_ie_q <= `R1;
      end else begin
         ctrl_a_q <= ctrl_a_d;
         ctrl_b_q <= ctrl_b_d;
         cap_q <= cap_d;
         cmpa_q <= cmpa_d;
         cmpb_q <= cmpb_d;
         latch_q <= latch_d; // [RULE1]
         rdata_q <= rdata_d;
         acsel_q <= acsel_d;
         ovf_q <= ovf_d;
         capf_q <= capf_d;
         ovf_ie_q <= ovf_ie_d;
         cap_ie_q <= cap_ie_d;
      end
   end

   // Outputs
   assign RDATA_O = rdata_q;
   assign OVF_IRQ_O = ovf_q & ovf_ie_q; // [RULE9]
   assign CAP_IRQ_O = capf_q & cap_ie_q; // [RULE12]

   // ************************************
   // Assertions
   // ************************************
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   a_latch_low_hold: assert property ( // [RULE1]
      cnt_wr |=> $stable(latch_q))
      else $error("latch changed on low write");

   a_stop_no_count: assert property ( // [RULE2]
      ctrl_b_q.cs == timer16_pkg::CS_STOP && !cnt_wr |=> $stable(cnt_q))
      else $error("counter moved while stopped");

   a_low_read_copy: assert property ( // [RULE3]
      req.rd && req.addr == `A_CNTL
      |=> latch_q == $past(cnt_q[`HI_B]) && RDATA_O == $past(cnt_q[`LO_B]))
      else $error("low read did not fill latch");

   a_write_beats_count: assert property ( // [RULE7]
      cnt_wr |=> cnt_q == {$past(latch_q), $past(req.wdata)})
      else $error("counter write lost");

   a_high_read_latch: assert property ( // [RULE4]
      req.rd && req.addr == `A_CNTH |=> RDATA_O == $past(latch_q))
      else $error("upper byte read not from latch");

   a_count_step: assert property ( // [RULE5]
      tick && !cnt_wr && kind == timer16_pkg::K_NORM
      |=> cnt_q == $past(cnt_q) + `STEP)
      else $error("normal count did not step");

   a_capture_copy: assert property ( // [RULE10]
      cap_evt |=> cap_q == $past(cnt_q) && capf_q)
      else $error("capture copy or flag missing");

   a_capture_ack: assert property ( // [RULE12]
      CAP_IRQ_ACK_I && !cap_evt |=> !capf_q && !CAP_IRQ_O)
      else $error("capture flag not cleared by ack");

   a_filter_four: assert property ( // [RULE18]
      ctrl_b_q.nf_en && $past(ctrl_b_q.nf_en) && !cap_top && !$past(cap_top)
      && !$past(cap_top, 2) && !$past(cap_top, 3) && !$past(cap_top, 4)
      && level != $past(level)
      |-> $past(src) == level && $past(src, 2) == level
      && $past(src, 3) == level && $past(src, 4) == level)
      else $error("filter changed too early");

   a_top_mode_frozen: assert property ( // [RULE17]
      cap_top && !cap_wr |=> $stable(cap_q) && !$past(cap_evt))
      else $error("capture in capture-top mode");

   a_overflow_set_wins: assert property ( // [RULE9]
      ovf_set && OVF_IRQ_ACK_I |=> ovf_q)
      else $error("overflow lost to clear");

   a_dual_bottom: assert property ( // [RULE24]
      kind == timer16_pkg::K_DUAL && tick && !cnt_wr && dir_q && cnt_q == `BOTTOM
      |=> ovf_q && !dir_q)
      else $error("dual slope bottom mishandled");

   c_capture: cover property (cap_evt ##1 capf_q);
   c_overflow: cover property (ovf_set ##1 ovf_q);
   c_filtered_capture: cover property (ctrl_b_q.nf_en && cap_evt);
   c_write_on_tick: cover property (cnt_wr && tick);

endmodule // timer16_core

// ---- testbench/io_bus_master.sv ----
// Processor-side model of the 8-bit I/O register bus
`timescale 1ns/1ps

module io_bus_master (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output logic [3:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   // Quiet bus at time zero
   initial begin
      addr_o = 4'h0;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   // One-cycle write strobe, released after the taking edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      wdata_o <= ~d;  // Stale data never mirrors the last write
   endtask

   // One-cycle read strobe, data taken in the cycle after it
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      #1 d = rdata_i;
   endtask
endmodule // io_bus_master

// ---- testbench/timer16_counter_input_capture_test.sv ----
// Self-checking testbench of the timer16 core
`timescale 1ns/1ps

module timer16_counter_input_capture_test;
   // ************************************************************
   // Clock, reset and wiring
   // ************************************************************
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   logic [3:0] ptick = 4'h0;
   logic ext_pin = 1'b0;
   logic cap_pin = 1'b0;
   logic comp_out = 1'b0;
   logic ovf_ack = 1'b0;
   logic cap_ack = 1'b0;
   logic ovf_irq;
   logic cap_irq;
   logic bottom;
   logic maxv;
   int err_total = 0;
   int samples_checked = 0;

   // 20 MHz system clock
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end

   timer16_core i_dut (
      .REF_CLK_I(ref_clk),
      .RST_N_I(rst_n),
      .ADDR_I(addr),
      .WDATA_I(wdata),
      .WR_I(wr),
      .RD_I(rd),
      .RDATA_O(rdata),
      .PRESCALE_TICK_I(ptick),
      .EXT_COUNT_PIN_I(ext_pin),
      .CAPTURE_PIN_I(cap_pin),
      .COMPARATOR_OUTPUT_I(comp_out),
      .OVF_IRQ_ACK_I(ovf_ack),
      .CAP_IRQ_ACK_I(cap_ack),
      .OVF_IRQ_O(ovf_irq),
      .CAP_IRQ_O(cap_irq),
      .BOTTOM_O(bottom),
      .MAX_O(maxv)
   );

   io_bus_master i_cpu (
      .clk_i(ref_clk),
      .rdata_i(rdata),
      .addr_o(addr),
      .wdata_o(wdata),
      .wr_o(wr),
      .rd_o(rd)
   );

   // ************************************************************
   // Shared tasks
   // ************************************************************
   // Compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic finish_test();
      if (err_total == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Wide write, high byte first
   task automatic w16(input logic [3:0] a, input logic [15:0] d);
      i_cpu.wr(a + 4'h1, d[15:8]);
      i_cpu.wr(a, d[7:0]);
   endtask

   // Wide read, low byte first
   task automatic r16(input logic [3:0] a, output logic [15:0] d);
      i_cpu.rd(a, d[7:0]);
      i_cpu.rd(a + 4'h1, d[15:8]);
   endtask

   // Source level step; flag must appear exactly one edge after lat
   task automatic src_step(input logic cmp, input logic lvl, input int lat, input logic hit);
      @(posedge ref_clk);
      if (cmp) begin
         comp_out <= lvl;
      end else begin
         cap_pin <= lvl;
      end
      repeat (lat) @(posedge ref_clk);
      #1 chk(cap_irq, 1'b0);
      @(posedge ref_clk);
      #1 chk(cap_irq, hit);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   // Values straight after reset, unmapped read
   task automatic t_reset();
      logic [7:0] b;
      chk(bottom, 1'b1);
      chk(maxv, 1'b0);
      chk(cap_irq, 1'b0);
      i_cpu.rd(4'h1, b);
      chk(b, 8'h00);
      i_cpu.rd(4'hd, b);
      chk(b, 8'h00);
   endtask

   // Shared high-byte latch, counter stopped
   task automatic t_latch();
      logic [7:0] b;
      logic [15:0] c;
      i_cpu.wr(4'h3, 8'h12);
      i_cpu.wr(4'h2, 8'h34);
      i_cpu.wr(4'h9, 8'h56);
      r16(4'h2, c);
      chk(c, 16'h1234);
      i_cpu.rd(4'h5, b);
      chk(b, 8'h12);
      i_cpu.rd(4'h9, c[7:0]);
      i_cpu.rd(4'ha, c[15:8]);
      chk(c, 16'h1256);
      i_cpu.wr(4'h3, 8'h77);
      r16(4'h2, c);
      chk(c, 16'h1234);
   endtask

   // Every prescaled and external source, then stop
   task automatic t_ticks();
      logic [15:0] c;
      w16(4'h2, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         i_cpu.wr(4'h1, 8'h02 + 8'(i));
         @(posedge ref_clk);
         ptick <= 4'h1 << i;
         @(posedge ref_clk);
         ptick <= 4'h0;
      end
      for (int k = 0; k < 2; k++) begin
         i_cpu.wr(4'h1, 8'h07 - 8'(k));
         @(posedge ref_clk);
         ext_pin <= 1'b1;
         repeat (5) @(posedge ref_clk);
         ext_pin <= 1'b0;
         repeat (5) @(posedge ref_clk);
      end
      i_cpu.wr(4'h1, 8'h00);
      @(posedge ref_clk);
      ptick <= 4'hf;
      @(posedge ref_clk);
      ptick <= 4'h0;
      r16(4'h2, c);
      chk(c, 16'h0006);
   endtask

   // Wrap at maximum, write priority over counting
   task automatic t_count();
      int n;
      n = 0;
      w16(4'h2, 16'hfffd);
      i_cpu.wr(4'h7, 8'h21);
      i_cpu.wr(4'h1, 8'h01);
      #1;
      while (maxv !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk(maxv, 1'b1);
      chk(ovf_irq, 1'b0);
      @(posedge ref_clk);
      #1 chk(bottom, 1'b1);
      chk(ovf_irq, 1'b1);
      w16(4'h2, 16'h0000);
      #1 chk(bottom, 1'b1);
      @(posedge ref_clk);
      #1 chk(bottom, 1'b0);
      i_cpu.wr(4'h1, 8'h00);
      @(posedge ref_clk);
      ovf_ack <= 1'b1;
      @(posedge ref_clk);
      ovf_ack <= 1'b0;
      #1 chk(ovf_irq, 1'b0);
      // Clear at compare A top: 3, 4, 5, then back to bottom
      w16(4'h9, 16'h0005);
      w16(4'h2, 16'h0003);
      i_cpu.wr(4'h1, 8'h09);
      repeat (3) @(posedge ref_clk);
      #1 chk(bottom, 1'b1);
      i_cpu.wr(4'h1, 8'h00);
   endtask

   // Fixed-top modes: overflow within bound, top never passed
   task automatic t_mode(input logic [7:0] ca, input logic [7:0] cb, input int lim);
      int n;
      logic [15:0] c;
      n = 0;
      i_cpu.wr(4'h0, ca);
      w16(4'h2, 16'h00fd);
      i_cpu.wr(4'h6, 8'h01);
      i_cpu.wr(4'h1, cb);
      #1;
      while (ovf_irq !== 1'b1 && n < lim) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk(ovf_irq, 1'b1);
      i_cpu.wr(4'h1, 8'h00);
      r16(4'h2, c);
      chk(c[15:8], 8'h00);
   endtask

   // Capture path: edges, filter, overwrite, clears, sources, freeze
   task automatic t_capture();
      logic [15:0] c;
      i_cpu.wr(4'h0, 8'h00);
      i_cpu.wr(4'h1, 8'h40);
      i_cpu.wr(4'h6, 8'h21);
      w16(4'h2, 16'h1234);
      src_step(1'b0, 1'b1, 2, 1'b1);
      r16(4'h4, c);
      chk(c, 16'h1234);
      @(posedge ref_clk);
      cap_ack <= 1'b1;
      @(posedge ref_clk);
      cap_ack <= 1'b0;
      #1 chk(cap_irq, 1'b0);
      src_step(1'b0, 1'b0, 2, 1'b0);
      w16(4'h2, 16'h5678);
      src_step(1'b0, 1'b1, 2, 1'b1);
      w16(4'h2, 16'h9abc);
      i_cpu.wr(4'h1, 8'h80);
      i_cpu.wr(4'h6, 8'h20);
      #1 chk(cap_irq, 1'b0);
      src_step(1'b0, 1'b0, 6, 1'b1);
      r16(4'h4, c);
      chk(c, 16'h9abc);
      i_cpu.wr(4'h6, 8'h20);
      @(posedge ref_clk);
      cap_pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      cap_pin <= 1'b0;
      repeat (12) @(posedge ref_clk);
      #1 chk(cap_irq, 1'b0);
      w16(4'h4, 16'hdead);
      r16(4'h4, c);
      chk(c, 16'h9abc);
      w16(4'h2, 16'h0777);
      i_cpu.wr(4'h1, 8'h40);
      i_cpu.wr(4'h8, 8'h04);
      i_cpu.wr(4'h6, 8'h20);
      src_step(1'b1, 1'b1, 2, 1'b1);
      r16(4'h4, c);
      chk(c, 16'h0777);
      i_cpu.wr(4'h1, 8'h18);
      i_cpu.wr(4'h6, 8'h20);
      w16(4'h4, 16'h0321);
      r16(4'h4, c);
      chk(c, 16'h0321);
      src_step(1'b1, 1'b0, 2, 1'b0);
      r16(4'h4, c);
      chk(c, 16'h0321);
   endtask

   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   // Reset for 8 cycles, then every scenario in turn
   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1 t_reset();
      t_latch();
      t_ticks();
      t_count();
      t_mode(8'h01, 8'h01, 600);
      t_mode(8'h01, 8'h09, 10);
      t_capture();
      finish_test();
   end

   // Hang guard at 20000 cycles, well beyond the few hundred cycles expected
   initial begin
      #(50 * 20000);
      err_total++;
      finish_test();
   end
endmodule // timer16_counter_input_capture_test
